// [verilog/bmsi_params.svh]
// Purpose: Constants for the buck mode and supply indicator control block.
// Assumes: 50 MHz pclk; APB byte addresses; comparator inputs active high.
// Notes: Register offsets and field positions used by top.
// Behaviour
// R1: Supply valid when AC or USB exceeds battery.
// R2: Indicator on when valid, off in sleep.
// R3: AC above overvoltage threshold is not valid.
// R4: Charger reset bit six floats the indicator.
// R5: Indicator follow, on, off or blink override.
// R6: Suspend charging when junction is too hot.
// R7: Main default target from main select pin.
// R8: Core default target from core select pin.
// R9: Host writes override pin-selected targets.
// R10: Deep sleep lowers or disables core converter.
// R11: Deep sleep pin ignored unless allow bit.
// R12: Bit seven forces PWM, blocks power save.
// R13: Light load in PWM enters power save.
// R14: Power save bursts at half rate between comparators.
// R15: Below nominal in power save returns to PWM.
// R16: Soft start raises current limit four steps.
// R17: Core turn-on lags main by 270 degrees.
// R18: High side on per clock, trip, dead, low side.
// R19: Shared fixed-frequency switching clock 1.25 MHz.
// R20: Optional discharge while converter is disabled.
// R21: Power-good readable while converter enabled.
// R22: Sleep when both AC and USB absent.
// R23: Comparator inputs pass two flip-flop synchronisers.
`ifndef BMSI_PARAMS_SVH
`define BMSI_PARAMS_SVH

// Clock and switching timing
`define BMSI_SYS_CLK_HZ 50000000
`define BMSI_PWM_FREQ_HZ 1250000
`define BMSI_PWM_PERIOD_CYC (`BMSI_SYS_CLK_HZ / `BMSI_PWM_FREQ_HZ)
`define BMSI_MAIN_LAG_DEG 0
`define BMSI_CORE_LAG_DEG 270
`define BMSI_MAIN_OFF_CYC (`BMSI_PWM_PERIOD_CYC * `BMSI_MAIN_LAG_DEG / 360)
`define BMSI_CORE_OFF_CYC (`BMSI_PWM_PERIOD_CYC * `BMSI_CORE_LAG_DEG / 360)
`define BMSI_DEAD_TIME_NS 20
`define BMSI_DEAD_CYC ((`BMSI_DEAD_TIME_NS * (`BMSI_SYS_CLK_HZ / 1000000) + 999) / 1000)
`define BMSI_SS_STEPS 4
`define BMSI_SS_STEP_US 64
`define BMSI_SS_STEP_CYC (`BMSI_SS_STEP_US * (`BMSI_SYS_CLK_HZ / 1000000))
`define BMSI_BLINK_TICK_MS 10
`define BMSI_BLINK_TICK_CYC (`BMSI_BLINK_TICK_MS * (`BMSI_SYS_CLK_HZ / 1000))

// Analog thresholds carried by the comparators outside
`define BMSI_SUPPLY_MARGIN_MV 100
`define BMSI_AC_OVP_MV 6600
`define BMSI_TJ_SUSPEND_C 145
`define BMSI_TJ_MARGIN_C 15
`define BMSI_TJ_SHUTDOWN_C (`BMSI_TJ_SUSPEND_C + `BMSI_TJ_MARGIN_C)

// Register byte offsets
`define BMSI_OFF_CHGCFG 12'h000
`define BMSI_OFF_ON_TIME 12'h004
`define BMSI_OFF_PERIOD 12'h008
`define BMSI_OFF_IND_MODE 12'h00C
`define BMSI_OFF_CONV_FIRST 12'h010
`define BMSI_OFF_CONV_SECOND 12'h014
`define BMSI_OFF_CONV_EN 12'h018
`define BMSI_OFF_STATUS 12'h01C

// Field positions
`define BMSI_CHG_RESET_BIT 6
`define BMSI_FPWM_BIT 7
`define BMSI_LP_ALLOW_BIT 6
`define BMSI_LP_CORE_OFF_BIT 5
`define BMSI_MAIN_DIS_BIT 4
`define BMSI_CORE_DIS_BIT 8

// Reset values and target codes
`define BMSI_RST_CHGCFG 8'h00
`define BMSI_RST_ON_TIME 8'h00
`define BMSI_RST_PERIOD 8'h00
`define BMSI_RST_CONV_FIRST 8'h00
`define BMSI_RST_CONV_SECOND 9'h000
`define BMSI_RST_CONV_EN 2'h3
`define BMSI_MAIN_3V0 4'h6
`define BMSI_MAIN_3V3 4'h9
`define BMSI_CORE_1V5 4'h5
`define BMSI_CORE_1V8 4'h8
`define BMSI_SS_FULL 2'h3

`endif

// [verilog/bmsi_pkg.sv]
// Purpose: Types for the buck mode and supply indicator control block.
// Assumes: Constants come from bmsi_params.svh.
// Notes: Index 0 of per-converter arrays is main, index 1 is core.
package bmsi_pkg;
    typedef enum logic [1:0] {SW_OFF, SW_HS, SW_DEAD, SW_LS} bmsi_sw_t;
    typedef enum logic {MODE_PWM, MODE_PSAVE} bmsi_mode_t;
    typedef enum logic [1:0] {IND_FOLLOW, IND_ON, IND_OFF, IND_BLINK} bmsi_ind_t;
endpackage

// [verilog/bmsi_sync.sv]
// Purpose: Two flip-flop synchroniser for a vector of levels.
// Assumes: Each bit is an independent level.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module bmsi_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bmsi_sync_state_t;

    bmsi_sync_state_t st;
    bmsi_sync_state_t next_st;

    // Shift through both stages
    always_comb
    begin
        next_st.meta = async_in;
        next_st.stable = st.meta;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule // bmsi_sync

// [verilog/bmsi_top.sv]
// Purpose: Buck converter switching, mode and supply indicator control.
// Assumes: APB slave, 32-bit data, answers in the first access cycle.
// Notes: Per-converter arrays use index 0 for main and 1 for core.
`timescale 1ns/1ps
`include "bmsi_params.svh"
module bmsi_top #(
    parameter int SS_STEP_CYC = `BMSI_SS_STEP_CYC,
    parameter int BLINK_TICK_CYC = `BMSI_BLINK_TICK_CYC
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration pins
    input wire logic main_default_select_pin,
    input wire logic core_default_select_pin,
    input wire logic deep_sleep_request_pin,
    // Charger comparators
    input wire logic ac_above_bat,
    input wire logic usb_above_bat,
    input wire logic ac_overvoltage,
    input wire logic ac_present,
    input wire logic usb_present,
    input wire logic tj_over_suspend,
    // Converter comparators, index 0 main, 1 core
    input wire logic [1:0] reg_trip,
    input wire logic [1:0] ilim_trip,
    input wire logic [1:0] light_load,
    input wire logic [1:0] below_comp_low,
    input wire logic [1:0] above_comp_high,
    input wire logic [1:0] below_nominal,
    input wire logic [1:0] power_good,
    // Converter drive
    output logic [1:0] hs_on,
    output logic [1:0] ls_on,
    output logic [1:0] conv_enable,
    output logic [1:0] discharge_on,
    output logic [1:0] main_ilim_step,
    output logic [1:0] core_ilim_step,
    output logic [3:0] main_target_code,
    output logic [3:0] core_target_code,
    output logic charge_suspend,
    // Open-drain supply valid indicator
    output logic supply_valid_indicator_o,
    output logic supply_valid_indicator_oe
);
    import bmsi_pkg::*;

    localparam int PERIOD = `BMSI_PWM_PERIOD_CYC;
    localparam int SSW = $clog2(SS_STEP_CYC + 1);
    localparam int BW = $clog2(BLINK_TICK_CYC + 1);
    localparam logic [5:0] MAIN_OFF = 6'(`BMSI_MAIN_OFF_CYC);
    localparam logic [5:0] CORE_OFF = 6'(`BMSI_CORE_OFF_CYC);

    typedef struct packed {
        logic [7:0] chgcfg;
        logic [7:0] on_time;
        logic [7:0] period;
        bmsi_ind_t ind_mode;
        logic [7:0] conv_first;
        logic [8:0] conv_second;
        logic [1:0] conv_en;
        logic strapped;
        logic [5:0] phase;
        logic [1:0] half;
        bmsi_mode_t [1:0] mode;
        logic [1:0] burst;
        bmsi_sw_t [1:0] sw;
        logic [1:0][3:0] dead_cnt;
        logic [1:0][1:0] ss;
        logic [1:0][SSW-1:0] ss_cnt;
        logic [BW-1:0] blink_pre;
        logic [7:0] blink_cnt;
        logic [1:0] hs;
        logic [1:0] ls;
        logic [1:0] en_out;
        logic [1:0] dis;
        logic [3:0] main_tgt;
        logic [3:0] core_tgt;
        logic suspend;
        logic ind_out;
        logic ind_oe;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } bmsi_state_t;

    bmsi_state_t st;
    bmsi_state_t next_st;

    logic [19:0] raw_in;
    logic [19:0] sync_in;
    logic ac_gt_s, usb_gt_s, ovp_s, ac_pres_s, usb_pres_s, tj_s;
    logic [1:0] reg_s, ilim_s, light_s, low_s, high_s, nom_s, pg_s;
    logic [1:0] tick, fire, eff_en;
    logic lp_act, valid, sleep, follow_on, ind_on, setup, access, hit;
    logic [31:0] rd_word;

    // Comparator synchronisers
    assign raw_in = {ac_above_bat, usb_above_bat, ac_overvoltage, ac_present, usb_present,
                     tj_over_suspend, reg_trip, ilim_trip, light_load, below_comp_low,
                     above_comp_high, below_nominal, power_good};

    bmsi_sync #(
        .WIDTH(20)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(raw_in), // R23
        .sync_out(sync_in)
    );

    assign {ac_gt_s, usb_gt_s, ovp_s, ac_pres_s, usb_pres_s, tj_s, reg_s, ilim_s, light_s,
            low_s, high_s, nom_s, pg_s} = sync_in;

    // Decode and status word
    always_comb
    begin
        valid = (ac_gt_s && !ovp_s) || usb_gt_s; // R1 R3
        sleep = !ac_pres_s && !usb_pres_s; // R22
        follow_on = valid && !sleep; // R2
        lp_act = deep_sleep_request_pin && st.conv_first[`BMSI_LP_ALLOW_BIT]; // R11
        eff_en[0] = st.conv_en[0];
        eff_en[1] = st.conv_en[1] && !(lp_act && st.conv_first[`BMSI_LP_CORE_OFF_BIT]); // R10
        setup = psel && !penable;
        access = psel && penable && st.ready;
        hit = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            `BMSI_OFF_CHGCFG: rd_word = {24'h00_0000, st.chgcfg};
            `BMSI_OFF_ON_TIME: rd_word = {24'h00_0000, st.on_time};
            `BMSI_OFF_PERIOD: rd_word = {24'h00_0000, st.period};
            `BMSI_OFF_IND_MODE: rd_word = {30'h0000_0000, st.ind_mode};
            `BMSI_OFF_CONV_FIRST: rd_word = {24'h00_0000, st.conv_first};
            `BMSI_OFF_CONV_SECOND: rd_word = {23'h00_0000, st.conv_second};
            `BMSI_OFF_CONV_EN: rd_word = {30'h0000_0000, st.conv_en};
            `BMSI_OFF_STATUS: rd_word = {24'h00_0000, st.ss[1] == `BMSI_SS_FULL &&
                                         st.ss[0] == `BMSI_SS_FULL,
                                         st.mode[1] == MODE_PSAVE, st.mode[0] == MODE_PSAVE,
                                         sleep, tj_s, pg_s & eff_en, follow_on}; // R21
            default: hit = 1'b0;
        endcase
    end

    // Next state of the whole block
    always_comb
    begin
        next_st = st;
        tick = 2'b00;
        fire = 2'b00;
        ind_on = 1'b0;

        // APB answer one cycle after setup
        next_st.ready = setup;
        next_st.slverr = setup && !hit;
        if (setup)
        begin
            next_st.rdata = rd_word;
        end

        // Pin defaults caught once after reset
        if (!st.strapped)
        begin
            next_st.strapped = 1'b1;
            next_st.conv_first[3:0] = main_default_select_pin ? `BMSI_MAIN_3V3
                                                              : `BMSI_MAIN_3V0; // R7
            next_st.conv_second[3:0] = core_default_select_pin ? `BMSI_CORE_1V8
                                                               : `BMSI_CORE_1V5; // R8
        end

        // Register writes at the access edge
        if (access && pwrite && hit)
        begin
            unique case (paddr)
                `BMSI_OFF_CHGCFG: next_st.chgcfg = pwdata[7:0];
                `BMSI_OFF_ON_TIME: next_st.on_time = pwdata[7:0];
                `BMSI_OFF_PERIOD: next_st.period = pwdata[7:0];
                `BMSI_OFF_IND_MODE: next_st.ind_mode = bmsi_ind_t'(pwdata[1:0]); // R5
                `BMSI_OFF_CONV_FIRST: next_st.conv_first = pwdata[7:0]; // R9
                `BMSI_OFF_CONV_SECOND: next_st.conv_second = pwdata[8:0]; // R9
                `BMSI_OFF_CONV_EN: next_st.conv_en = pwdata[1:0];
                default: next_st.conv_en = st.conv_en;
            endcase
        end

        // Shared switching clock phase
        next_st.phase = (st.phase == 6'(PERIOD - 1)) ? 6'h00 : st.phase + 6'h01; // R19

        // Per-converter control
        for (int c = 0; c < 2; c++)
        begin
            tick[c] = (st.phase == ((c == 0) ? MAIN_OFF : CORE_OFF)); // R17
            if (!eff_en[c])
            begin
                next_st.mode[c] = MODE_PWM;
                next_st.burst[c] = 1'b0;
                next_st.sw[c] = SW_OFF;
                next_st.ss[c] = 2'h0;
                next_st.ss_cnt[c] = '0;
                next_st.half[c] = 1'b0;
            end
            else
            begin
                // Soft start current limit steps
                if (st.ss[c] != `BMSI_SS_FULL)
                begin
                    if (st.ss_cnt[c] == SSW'(SS_STEP_CYC - 1))
                    begin
                        next_st.ss_cnt[c] = '0;
                        next_st.ss[c] = st.ss[c] + 2'h1; // R16
                    end
                    else
                    begin
                        next_st.ss_cnt[c] = st.ss_cnt[c] + SSW'(1);
                    end
                end
                // Mode selection
                unique case (st.mode[c])
                    MODE_PWM:
                    begin
                        if (!st.conv_first[`BMSI_FPWM_BIT] && light_s[c]) // R12 R13
                        begin
                            next_st.mode[c] = MODE_PSAVE;
                            next_st.burst[c] = 1'b0;
                        end
                    end
                    MODE_PSAVE:
                    begin
                        if (st.conv_first[`BMSI_FPWM_BIT] || nom_s[c]) // R12 R15
                        begin
                            next_st.mode[c] = MODE_PWM;
                        end
                        else if (high_s[c])
                        begin
                            next_st.burst[c] = 1'b0; // R14
                        end
                        else if (low_s[c])
                        begin
                            next_st.burst[c] = 1'b1; // R14
                        end
                    end
                endcase
                // Half-rate gating for power save bursts
                if (tick[c])
                begin
                    next_st.half[c] = !st.half[c];
                end
                fire[c] = tick[c] && (st.mode[c] == MODE_PWM ||
                                      (st.burst[c] && st.half[c])); // R14
                // Switch sequence
                unique case (st.sw[c])
                    SW_OFF:
                    begin
                        if (fire[c])
                        begin
                            next_st.sw[c] = SW_HS; // R18
                        end
                    end
                    SW_HS:
                    begin
                        if (reg_s[c] || ilim_s[c])
                        begin
                            next_st.sw[c] = SW_DEAD; // R18
                            next_st.dead_cnt[c] = 4'h0;
                        end
                    end
                    SW_DEAD:
                    begin
                        if (st.dead_cnt[c] == 4'(`BMSI_DEAD_CYC - 1))
                        begin
                            next_st.sw[c] = SW_LS; // R18
                        end
                        else
                        begin
                            next_st.dead_cnt[c] = st.dead_cnt[c] + 4'h1;
                        end
                    end
                    SW_LS:
                    begin
                        if (tick[c])
                        begin
                            next_st.sw[c] = fire[c] ? SW_HS : SW_OFF; // R18
                        end
                    end
                endcase
            end
            next_st.hs[c] = (next_st.sw[c] == SW_HS);
            next_st.ls[c] = (next_st.sw[c] == SW_LS);
        end

        // Converter side outputs
        next_st.en_out = eff_en;
        next_st.dis[0] = st.conv_first[`BMSI_MAIN_DIS_BIT] && !eff_en[0]; // R20
        next_st.dis[1] = st.conv_second[`BMSI_CORE_DIS_BIT] && !eff_en[1]; // R20
        next_st.main_tgt = st.conv_first[3:0];
        next_st.core_tgt = (lp_act && !st.conv_first[`BMSI_LP_CORE_OFF_BIT]) ?
                           st.conv_second[7:4] : st.conv_second[3:0]; // R10
        next_st.suspend = tj_s; // R6

        // Blink timebase, runs only in blink mode
        if (st.ind_mode != IND_BLINK)
        begin
            next_st.blink_pre = '0;
            next_st.blink_cnt = 8'h00;
        end
        else if (st.blink_pre == BW'(BLINK_TICK_CYC - 1))
        begin
            next_st.blink_pre = '0;
            next_st.blink_cnt = (st.blink_cnt >= st.period) ? 8'h00 : st.blink_cnt + 8'h01;
        end
        else
        begin
            next_st.blink_pre = st.blink_pre + BW'(1);
        end

        // Indicator source selection
        unique case (st.ind_mode)
            IND_FOLLOW: ind_on = follow_on; // R2
            IND_ON: ind_on = 1'b1; // R5
            IND_OFF: ind_on = 1'b0; // R5
            IND_BLINK: ind_on = (st.blink_cnt < st.on_time); // R5
        endcase
        next_st.ind_out = 1'b0;
        next_st.ind_oe = ind_on && !st.chgcfg[`BMSI_CHG_RESET_BIT]; // R4
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.chgcfg <= `BMSI_RST_CHGCFG;
            st.on_time <= `BMSI_RST_ON_TIME;
            st.period <= `BMSI_RST_PERIOD;
            st.conv_first <= `BMSI_RST_CONV_FIRST;
            st.conv_second <= `BMSI_RST_CONV_SECOND;
            st.conv_en <= `BMSI_RST_CONV_EN;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    // Ports straight from state
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign hs_on = st.hs;
    assign ls_on = st.ls;
    assign conv_enable = st.en_out;
    assign discharge_on = st.dis;
    assign main_ilim_step = st.ss[0];
    assign core_ilim_step = st.ss[1];
    assign main_target_code = st.main_tgt;
    assign core_target_code = st.core_tgt;
    assign charge_suspend = st.suspend;
    assign supply_valid_indicator_o = st.ind_out;
    assign supply_valid_indicator_oe = st.ind_oe;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IND_HIZ: assert property (ce && st.chgcfg[`BMSI_CHG_RESET_BIT] |=> !st.ind_oe) // R4
        else $error("indicator driven while charger in reset");
    AST_IND_FOLLOW: assert property (ce && st.ind_mode == IND_FOLLOW &&
        !st.chgcfg[`BMSI_CHG_RESET_BIT] |=> st.ind_oe == $past(follow_on)) // R1
        else $error("indicator does not follow supply valid");
    AST_FPWM: assert property (ce && st.conv_first[`BMSI_FPWM_BIT] && eff_en[0] |=>
        st.mode[0] == MODE_PWM) // R12
        else $error("power save held under forced PWM");
    AST_PSAVE_IN: assert property (ce && eff_en[1] && st.mode[1] == MODE_PWM &&
        !st.conv_first[`BMSI_FPWM_BIT] && light_s[1] |=> st.mode[1] == MODE_PSAVE) // R13
        else $error("light load did not enter power save");
    AST_LP_IGNORED: assert property (ce && !st.conv_first[`BMSI_LP_ALLOW_BIT] |=>
        st.en_out[1] == $past(st.conv_en[1]) && st.core_tgt == $past(st.conv_second[3:0])) // R11
        else $error("deep sleep acted without allow bit");
    AST_NO_SHOOT: assert property (!(st.hs[0] && st.ls[0]) && !(st.hs[1] && st.ls[1])) // R18
        else $error("high and low side on together");
    AST_LS_AFTER_HS: assert property ($rose(st.ls[0]) |-> $past(st.sw[0]) == SW_DEAD) // R18
        else $error("low side without dead time");
    AST_MAIN_PHASE: assert property ($rose(st.hs[0]) |-> st.phase == MAIN_OFF + 6'h01) // R17
        else $error("main turn-on off phase");
    AST_CORE_PHASE: assert property ($rose(st.hs[1]) |-> st.phase == CORE_OFF + 6'h01) // R17
        else $error("core turn-on off phase");
    AST_SS_STEP: assert property (ce && eff_en[0] && st.ss[0] != `BMSI_SS_FULL |=>
        st.ss[0] == $past(st.ss[0]) || st.ss[0] == $past(st.ss[0]) + 2'h1) // R16
        else $error("soft start skipped a step");
    AST_DISCHARGE: assert property (ce && eff_en[1] |=> !st.dis[1]) // R20
        else $error("discharge while core enabled");
endmodule // bmsi_top

// [verilog/none_placeholder_removed.sv]
// Purpose: Holds no logic.
// Assumes: Nothing.
// Notes: Block logic is in bmsi_top.

// [sim/bmsi_stage_model.sv]
// Purpose: Power stage and comparator model on the far side of the block.
// Assumes: Inductor ramps while the high side is on; trips after a few cycles.
// Notes: The lite input turns the load light for power save tests.
`timescale 1ns/1ps
module bmsi_stage_model (
    // Clock and switch drive
    input wire logic pclk,
    input wire logic [1:0] hs_on,
    input wire logic lite,
    // Comparator levels, index 0 main, 1 core
    output logic [1:0] reg_trip,
    output logic [1:0] ilim_trip,
    output logic [1:0] light_load,
    output logic [1:0] below_comp_low,
    output logic [1:0] above_comp_high,
    output logic [1:0] below_nominal,
    output logic [1:0] power_good
);
    logic [3:0] ramp [2];

    // Current ramps while high side is on, resets otherwise
    always @(posedge pclk)
    begin
        for (int i = 0; i < 2; i++)
            ramp[i] <= hs_on[i] ? ramp[i] + 4'h1 : 4'h0;
    end

    // Regulation trip early, current limit later as a backstop
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            reg_trip[i] = (ramp[i] >= 4'h6);
            ilim_trip[i] = (ramp[i] >= 4'hC);
        end
    end
    assign light_load = {2{lite}};
    assign below_comp_low = {2{lite}};
    assign above_comp_high = 2'h0;
    assign below_nominal = {2{~lite}};
    assign power_good = 2'h3;
endmodule // bmsi_stage_model

// [sim/buck_mode_and_supply_indicator_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the buck mode and indicator control.
// Assumes: Short soft start and blink tick parameters of 4 cycles.
// Notes: Registers reached over APB; converter comparators come from the stage model, charger comparators from the bench.
`timescale 1ns/1ps
module buck_mode_and_supply_indicator_ctrl_tb_top;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, lite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, ms = 1, cs = 0, dsp = 0;
    logic ab = 0, ub = 0, ov = 0, ap = 0, up = 0, tj = 0;
    logic [1:0] rt, it, ll, bl, ah, bn, pg, hs_on, ls_on, cen, dis, mst, cst;
    logic [3:0] mtc, ctc;
    logic csus, ind_o, ind_oe;
    int err_total = 0, num_checks = 0, cyc = 0, t0, t1, t2;

    bmsi_top #(.SS_STEP_CYC(4), .BLINK_TICK_CYC(4)) dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .main_default_select_pin(ms),
        .core_default_select_pin(cs), .deep_sleep_request_pin(dsp),
        .ac_above_bat(ab), .usb_above_bat(ub), .ac_overvoltage(ov), .ac_present(ap),
        .usb_present(up), .tj_over_suspend(tj), .reg_trip(rt), .ilim_trip(it),
        .light_load(ll), .below_comp_low(bl), .above_comp_high(ah), .below_nominal(bn),
        .power_good(pg), .hs_on(hs_on), .ls_on(ls_on), .conv_enable(cen),
        .discharge_on(dis), .main_ilim_step(mst), .core_ilim_step(cst),
        .main_target_code(mtc), .core_target_code(ctc), .charge_suspend(csus),
        .supply_valid_indicator_o(ind_o), .supply_valid_indicator_oe(ind_oe));
    bmsi_stage_model model (
        .pclk(pclk), .hs_on(hs_on), .lite(lite), .reg_trip(rt), .ilim_trip(it),
        .light_load(ll), .below_comp_low(bl), .above_comp_high(ah),
        .below_nominal(bn), .power_good(pg));

    // Clock and hang limit
    always #10 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            close_out();
        end
    end

    // Verdict and end of run
    task close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One comparison
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Wait for a rising high-side drive of converter i
    task rise(input int i, output int t);
        while (hs_on[i] !== 1'b0)
            @(posedge pclk);
        while (hs_on[i] !== 1'b1)
            @(posedge pclk);
        t = cyc;
    endtask

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        chk("main_target", 32'h9, mtc);
        chk("core_target", 32'h5, ctc);
        xfer(0, 12'h010, 0);
        chk("conv_first", 32'h9, q & 32'hF);
        xfer(1, 12'h014, 32'h38);
        xfer(1, 12'h010, 32'h06);
        repeat (3) @(posedge pclk);
        chk("main_prog", 32'h6, mtc);
        chk("core_prog", 32'h8, ctc);
        chk("ilim_full", 32'h3, mst);
        $display("test targets done");
        rise(0, t0);
        rise(1, t1);
        rise(0, t2);
        chk("core_lag", 32'd30, t1 - t0);
        chk("period", 32'd40, t2 - t0);
        repeat (20) @(posedge pclk);
        chk("low_side", 32'h1, {hs_on[0], ls_on[0]});
        $display("test switching done");
        dsp <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("lp_ignored", 32'h8, ctc);
        xfer(1, 12'h010, 32'h46);
        repeat (3) @(posedge pclk);
        chk("lp_lower", 32'h3, ctc);
        xfer(1, 12'h010, 32'h66);
        repeat (3) @(posedge pclk);
        chk("lp_off", 32'h1, cen);
        dsp <= 1'b0;
        xfer(1, 12'h010, 32'h16);
        xfer(1, 12'h018, 32'h0);
        repeat (3) @(posedge pclk);
        chk("discharge", 32'h1, dis);
        chk("ilim_reset", 32'h0, mst);
        xfer(0, 12'h01C, 0);
        chk("pgood_off", 32'h0, q & 32'h6);
        xfer(1, 12'h018, 32'h3);
        ce <= 1'b0;
        repeat (30) @(posedge pclk);
        chk("ce_hold", 32'h0, cst);
        ce <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("ilim_restart", 32'h3, cst);
        xfer(0, 12'h01C, 0);
        chk("pgood_on", 32'h6, q & 32'h6);
        $display("test converters done");
        lite <= 1'b1;
        repeat (60) @(posedge pclk);
        xfer(0, 12'h01C, 0);
        chk("psave_in", 32'h60, q & 32'h60);
        xfer(1, 12'h010, 32'h86);
        xfer(0, 12'h01C, 0);
        chk("force_pwm", 32'h0, q & 32'h60);
        xfer(1, 12'h010, 32'h06);
        repeat (60) @(posedge pclk);
        lite <= 1'b0;
        repeat (6) @(posedge pclk);
        xfer(0, 12'h01C, 0);
        chk("psave_out", 32'h0, q & 32'h60);
        $display("test modes done");
        ab <= 1'b1;
        ap <= 1'b1;
        tj <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("ind_ac", 32'h1, ind_oe);
        chk("suspend", 32'h1, csus);
        ov <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("ind_ovp", 32'h0, ind_oe);
        ub <= 1'b1;
        ap <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("ind_sleep", 32'h0, ind_oe);
        xfer(1, 12'h00C, 32'h1);
        repeat (3) @(posedge pclk);
        chk("ind_forced", 32'h1, ind_oe);
        xfer(1, 12'h000, 32'h40);
        repeat (3) @(posedge pclk);
        chk("ind_float", 32'h0, {ind_o, ind_oe});
        xfer(0, 12'h020, 0);
        chk("unmapped", 32'h1, {q[30:0], e});
        $display("test indicator done");
        close_out();
    end
endmodule // buck_mode_and_supply_indicator_ctrl_tb_top
